/* tsr_pkg.sv */
// Shared constants of the temperature sensor register bank.
`default_nettype none
package tsr_pkg;
  // ****************************************************************
  // Register pointers.
  // ****************************************************************
  localparam logic [7:0] TSR_PTR_LOCAL_WHOLE = 8'h00;
  localparam logic [7:0] TSR_PTR_REMOTE_S_WHOLE = 8'h01;
  localparam logic [7:0] TSR_PTR_STATUS_FIRST = 8'h02;
  localparam logic [7:0] TSR_PTR_GEN_CFG_A = 8'h03;
  localparam logic [7:0] TSR_PTR_CONV_INT_A = 8'h04;
  localparam logic [7:0] TSR_PTR_REMOTE_OT_A = 8'h07;
  localparam logic [7:0] TSR_PTR_GEN_CFG_B = 8'h09;
  localparam logic [7:0] TSR_PTR_CONV_INT_B = 8'h0A;
  localparam logic [7:0] TSR_PTR_REMOTE_OT_B = 8'h0D;
  localparam logic [7:0] TSR_PTR_ONE_SHOT = 8'h0F;
  localparam logic [7:0] TSR_PTR_REMOTE_S_FRAC = 8'h10;
  localparam logic [7:0] TSR_PTR_OFFSET_HIGH = 8'h11;
  localparam logic [7:0] TSR_PTR_OFFSET_LOW = 8'h12;
  localparam logic [7:0] TSR_PTR_REMOTE_CRIT = 8'h19;
  localparam logic [7:0] TSR_PTR_LOCAL_LIMIT = 8'h20;
  localparam logic [7:0] TSR_PTR_HYSTERESIS = 8'h21;
  localparam logic [7:0] TSR_PTR_LOCAL_FRAC = 8'h30;
  localparam logic [7:0] TSR_PTR_REMOTE_U_WHOLE = 8'h31;
  localparam logic [7:0] TSR_PTR_REMOTE_U_FRAC = 8'h32;
  localparam logic [7:0] TSR_PTR_STATUS_SECOND = 8'h33;
  localparam logic [7:0] TSR_PTR_DIODE_CFG = 8'hBF;
  localparam logic [7:0] TSR_PTR_MAKER = 8'hFE;
  localparam logic [7:0] TSR_PTR_REVISION = 8'hFF;
  localparam logic [7:0] TSR_PTR_RESET = 8'h00;
  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] TSR_RST_GEN_CFG = 8'h00;
  localparam logic [7:0] TSR_RST_CONV_INT = 8'h02;
  localparam logic [7:0] TSR_RST_REMOTE_OT = 8'h55;
  localparam logic [7:0] TSR_RST_REMOTE_CRIT = 8'h6E;
  localparam logic [7:0] TSR_RST_LOCAL_LIMIT = 8'h55;
  localparam logic [7:0] TSR_RST_HYSTERESIS = 8'h0A;
  localparam logic [7:0] TSR_RST_OFFSET = 8'h00;
  localparam logic [7:0] TSR_RST_DIODE_CFG = 8'h1F;
  localparam logic [7:0] TSR_ZERO_BYTE = 8'h00;
  // ****************************************************************
  // Masks of bits that exist; other bits read as zero, except diode configuration bit 0, which is forced to one.
  // ****************************************************************
  localparam logic [7:0] TSR_MASK_GEN_CFG = 8'h5E;
  localparam logic [7:0] TSR_MASK_CONV_INT = 8'h03;
  localparam logic [7:0] TSR_MASK_LOCAL_LIMIT = 8'h7F;
  localparam logic [7:0] TSR_MASK_HYSTERESIS = 8'h1F;
  localparam logic [7:0] TSR_MASK_OFFSET_LOW = 8'hE0;
  localparam logic [7:0] TSR_MASK_DIODE_CFG = 8'h7E;
  localparam logic [7:0] TSR_FORCE_DIODE_CFG = 8'h01;
  localparam logic [7:0] TSR_MASK_FRAC_COARSE = 8'hE0;
  localparam logic [7:0] TSR_MASK_FRAC_FINE = 8'hF8;
  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int TSR_GC_STANDBY = 6;
  localparam int TSR_GC_REMOTE_CRIT_MASK = 4;
  localparam int TSR_GC_REMOTE_OT_MASK = 3;
  localparam int TSR_GC_LOCAL_CRIT_MASK = 2;
  localparam int TSR_GC_LOCAL_OT_MASK = 1;
  localparam int TSR_DC_PIN_IS_ALARM = 6;
  localparam int TSR_DC_FAULT_MASK_OT = 5;
  localparam int TSR_DC_FAULT_MASK_CRIT = 4;
  localparam int TSR_DC_DIODE_MODEL = 3;
  localparam int TSR_DC_FILTER_HI = 2;
  localparam int TSR_DC_FILTER_LO = 1;
  localparam int TSR_S1_BUSY = 7;
  localparam int TSR_S1_REMOTE_OT = 4;
  localparam int TSR_S1_FAULT = 2;
  localparam int TSR_S1_REMOTE_CRIT = 1;
  localparam int TSR_S1_LOCAL = 0;
  localparam int TSR_S2_NOT_READY = 7;
  localparam int TSR_S2_DIODE_DETECT = 0;
  localparam int TSR_SIGN_BIT = 7;
  localparam logic [1:0] TSR_FILTER_ON = 2'b11;
endpackage
`default_nettype wire

/* tsr_frac_lock.sv */
// Fraction byte that freezes when its whole-degree byte is read.
`default_nettype none
module tsr_frac_lock (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // Live fraction and read events.
  input wire logic [7:0] liveFrac,
  input wire logic wholeRead,
  input wire logic fracRead,
  // Fraction as seen by a read.
  output logic [7:0] shownFrac
);
  import tsr_pkg::*;

  logic lockedReg;
  logic [7:0] heldReg;

  // A whole read freezes the live fraction; a fraction read releases it.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lockedReg <= 1'b0;
      heldReg <= TSR_ZERO_BYTE;
    end
    else if (clkEn)
    begin
      if (wholeRead)
      begin
        lockedReg <= 1'b1;
        heldReg <= liveFrac;
      end
      else if (fracRead)
      begin
        lockedReg <= 1'b0;
      end
    end
  end

  // The frozen copy wins while the lock stands.
  assign shownFrac = lockedReg ? heldReg : liveFrac;
endmodule
`default_nettype wire

/* tsr_hyst_alarm.sv */
// One alarm comparator over both channels with shared hysteresis.
`default_nettype none
module tsr_hyst_alarm (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // Conversion result.
  input wire logic update,
  input wire logic [7:0] localTemp,
  input wire logic [7:0] remoteTemp,
  input wire logic remoteFault,
  // Thresholds and masks.
  input wire logic [7:0] localLimit,
  input wire logic [7:0] remoteLimit,
  input wire logic [7:0] hysteresis,
  input wire logic localMask,
  input wire logic remoteMask,
  input wire logic faultMask,
  // Alarm level, high while active.
  output logic alarm
);
  import tsr_pkg::*;

  logic localOver;
  logic remoteOver;
  logic localLow;
  logic remoteLow;
  logic [8:0] localFloor;
  logic [8:0] remoteFloor;

  // Limits are unsigned; a negative local reading is never over.
  assign localFloor = {1'b0, localLimit} - {1'b0, hysteresis};
  assign remoteFloor = {1'b0, remoteLimit} - {1'b0, hysteresis};
  assign localOver = !localTemp[TSR_SIGN_BIT] && (localTemp > localLimit);
  assign remoteOver = (remoteTemp > remoteLimit) ||
    (remoteFault && !faultMask);
  assign localLow = localTemp[TSR_SIGN_BIT] || localMask ||
    (!localFloor[8] && ({1'b0, localTemp} < localFloor));
  assign remoteLow = remoteMask ||
    (!remoteFloor[8] && ({1'b0, remoteTemp} < remoteFloor));

  // Sets on any unmasked excess; releases only when both are low.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      alarm <= 1'b0;
    else if (clkEn && update)
    begin
      if ((localOver && !localMask) || (remoteOver && !remoteMask))
        alarm <= 1'b1;
      else if (localLow && remoteLow && !(remoteFault && !faultMask))
        alarm <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* tsr_register_bank.sv */
// Register bank of the two-channel temperature sensor.
`default_nettype none
// Overview of operation
// - Command byte sets pointer for later accesses.
// - Pointer 00h reads local signed whole degrees.
// - Pointer 30h reads local fraction, three bits.
// - Pointer 01h reads remote signed whole degrees.
// - Filter on gives five signed fraction bits.
// - Pointers 31h/32h read unsigned remote temperature.
// - Undefined temperature and offset bits read zero.
// - Diode configuration at BFh, resets 1Fh.
// - Remote offset high/low bytes, reset zero.
// - General configuration at 03h and 09h.
// - Two-bit conversion interval at 04h/0Ah, reset 02h.
// - Write to 0Fh starts one standby conversion.
// - First status at 02h shows busy, alarms.
// - Second status at 33h: not-ready, diode detect.
// - Remote limits unsigned; reset 55h and 6Eh.
// - Local shared limit seven bits, reset 55h.
// - Pointer is zero after reset.
// - Remote whole read freezes remote fraction until fraction read.
// - Remote fraction step 0.125 unfiltered, 0.03125 filtered.
// - Alarms release when both below limit minus hysteresis.
module tsr_register_bank #(
  parameter int DATA_W = 8,
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] REVISION_CODE = 8'h3C
) (
  // Clock, reset and clock enable.
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // Byte-level register port from the serial interface.
  input wire logic cmdValid,
  input wire logic [DATA_W-1:0] cmdByte,
  input wire logic wrValid,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic rdStrobe,
  output logic [DATA_W-1:0] rdData,
  // Results from the conversion engine.
  input wire logic convDone,
  input wire logic convBusy,
  input wire logic convNotReady,
  input wire logic diodeDetected,
  input wire logic diodeFault,
  input wire logic [7:0] localWhole,
  input wire logic [7:0] localFrac,
  input wire logic [7:0] remoteSignedWhole,
  input wire logic [7:0] remoteSignedFrac,
  input wire logic [7:0] remoteUnsignedWhole,
  input wire logic [7:0] remoteUnsignedFrac,
  // Controls to the conversion engine.
  output logic standbyMode,
  output logic [1:0] convInterval,
  output logic oneShotStart,
  output logic [1:0] filterSelect,
  output logic diodeModel,
  output logic [7:0] offsetHigh,
  output logic [7:0] offsetLow,
  // Alarm pins, active low, and pin function select.
  output logic overtemp_alarm_output_n,
  output logic critAlarm_n,
  output logic alarm_or_address_pin_is_alarm
);
  import tsr_pkg::*;

  // ****************************************************************
  // Parameter check.
  // ****************************************************************
  if (DATA_W != 8)
  begin : gBadWidth
    $error("tsr_register_bank supports only an 8-bit data path.");
  end

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [7:0] pointer_bits_reg;
  logic [7:0] genCfg_reg;
  logic [7:0] convInt_reg;
  logic [7:0] remoteOt_reg;
  logic [7:0] remoteCrit_reg;
  logic [7:0] localLimit_reg;
  logic [7:0] hyst_reg;
  logic [7:0] offHigh_reg;
  logic [7:0] offLow_reg;
  logic [7:0] diodeCfg_reg;
  logic [7:0] localWhole_reg;
  logic [7:0] localFrac_reg;
  logic [7:0] remSWhole_reg;
  logic [7:0] remSFrac_reg;
  logic [7:0] remUWhole_reg;
  logic [7:0] remUFrac_reg;
  logic statRemOt_reg;
  logic statRemCrit_reg;
  logic statLocal_reg;
  logic statFault_reg;
  logic [7:0] rdData_next;
  logic [7:0] shownSFrac;
  logic [7:0] shownUFrac;
  logic [7:0] fracMask;
  logic filterOn;
  logic otAlarm;
  logic critAlarm;
  logic wrOk;
  logic rdSWhole;
  logic rdSFrac;
  logic rdUWhole;
  logic rdUFrac;

  // Write qualifier and read events for the fraction locks.
  assign wrOk = clkEn && wrValid;
  assign rdSWhole = rdStrobe && (pointer_bits_reg == TSR_PTR_REMOTE_S_WHOLE);
  assign rdSFrac = rdStrobe && (pointer_bits_reg == TSR_PTR_REMOTE_S_FRAC);
  assign rdUWhole = rdStrobe && (pointer_bits_reg == TSR_PTR_REMOTE_U_WHOLE);
  assign rdUFrac = rdStrobe && (pointer_bits_reg == TSR_PTR_REMOTE_U_FRAC);

  // Fraction resolution follows the filter field.
  assign filterOn = (diodeCfg_reg[TSR_DC_FILTER_HI:TSR_DC_FILTER_LO] ==
    TSR_FILTER_ON);
  assign fracMask = filterOn ? TSR_MASK_FRAC_FINE
                             : TSR_MASK_FRAC_COARSE;

  // ****************************************************************
  // Pointer.
  // ****************************************************************
  // The command byte replaces the pointer; it clears at reset.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pointer_bits_reg <= TSR_PTR_RESET;
    else if (clkEn && cmdValid)
      pointer_bits_reg <= cmdByte;
  end

  // ****************************************************************
  // Writable registers.
  // ****************************************************************
  // Configuration and interval, each reached by two pointers.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      genCfg_reg <= TSR_RST_GEN_CFG;
      convInt_reg <= TSR_RST_CONV_INT;
    end
    else if (wrOk)
    begin
      case (pointer_bits_reg)
        TSR_PTR_GEN_CFG_A, TSR_PTR_GEN_CFG_B:
          genCfg_reg <= wrData & TSR_MASK_GEN_CFG;
        TSR_PTR_CONV_INT_A, TSR_PTR_CONV_INT_B:
          convInt_reg <= wrData & TSR_MASK_CONV_INT;
        default:
          genCfg_reg <= genCfg_reg;
      endcase
    end
  end

  // Limit and hysteresis registers.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      remoteOt_reg <= TSR_RST_REMOTE_OT;
      remoteCrit_reg <= TSR_RST_REMOTE_CRIT;
      localLimit_reg <= TSR_RST_LOCAL_LIMIT;
      hyst_reg <= TSR_RST_HYSTERESIS;
    end
    else if (wrOk)
    begin
      case (pointer_bits_reg)
        TSR_PTR_REMOTE_OT_A, TSR_PTR_REMOTE_OT_B:
          remoteOt_reg <= wrData;
        TSR_PTR_REMOTE_CRIT:
          remoteCrit_reg <= wrData;
        TSR_PTR_LOCAL_LIMIT:
          localLimit_reg <= wrData & TSR_MASK_LOCAL_LIMIT;
        TSR_PTR_HYSTERESIS:
          hyst_reg <= wrData & TSR_MASK_HYSTERESIS;
        default:
          hyst_reg <= hyst_reg;
      endcase
    end
  end

  // Diode configuration and offset; read-only pointers fall through.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      offHigh_reg <= TSR_RST_OFFSET;
      offLow_reg <= TSR_RST_OFFSET;
      diodeCfg_reg <= TSR_RST_DIODE_CFG;
    end
    else if (wrOk)
    begin
      case (pointer_bits_reg)
        TSR_PTR_OFFSET_HIGH:
          offHigh_reg <= wrData;
        TSR_PTR_OFFSET_LOW:
          offLow_reg <= wrData & TSR_MASK_OFFSET_LOW;
        TSR_PTR_DIODE_CFG:
          diodeCfg_reg <= (wrData & TSR_MASK_DIODE_CFG) |
            TSR_FORCE_DIODE_CFG;
        default:
          diodeCfg_reg <= diodeCfg_reg;
      endcase
    end
  end

  // ****************************************************************
  // One-shot trigger.
  // ****************************************************************
  // A pulse only in standby with no conversion under way; no data kept.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      oneShotStart <= 1'b0;
    else if (clkEn)
      oneShotStart <= wrValid && (pointer_bits_reg == TSR_PTR_ONE_SHOT) &&
        genCfg_reg[TSR_GC_STANDBY] && !convBusy;
  end

  // ****************************************************************
  // Conversion results.
  // ****************************************************************
  // Each finished conversion refreshes the result bytes and flags.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      localWhole_reg <= TSR_ZERO_BYTE;
      localFrac_reg <= TSR_ZERO_BYTE;
      remSWhole_reg <= TSR_ZERO_BYTE;
      remSFrac_reg <= TSR_ZERO_BYTE;
      remUWhole_reg <= TSR_ZERO_BYTE;
      remUFrac_reg <= TSR_ZERO_BYTE;
    end
    else if (clkEn && convDone)
    begin
      localWhole_reg <= localWhole;
      localFrac_reg <= localFrac & TSR_MASK_FRAC_COARSE;
      remSWhole_reg <= remoteSignedWhole;
      remSFrac_reg <= remoteSignedFrac & fracMask;
      remUWhole_reg <= remoteUnsignedWhole;
      remUFrac_reg <= remoteUnsignedFrac & fracMask;
    end
  end

  // Limit flags compare each new result with its limit; the fault flag copies diodeFault.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      statRemOt_reg <= 1'b0;
      statRemCrit_reg <= 1'b0;
      statLocal_reg <= 1'b0;
      statFault_reg <= 1'b0;
    end
    else if (clkEn && convDone)
    begin
      statRemOt_reg <= remoteUnsignedWhole > remoteOt_reg;
      statRemCrit_reg <= remoteUnsignedWhole > remoteCrit_reg;
      statLocal_reg <= !localWhole[TSR_SIGN_BIT] &&
        (localWhole > localLimit_reg);
      statFault_reg <= diodeFault;
    end
  end

  // ****************************************************************
  // Fraction locks.
  // ****************************************************************
  tsr_frac_lock uSignedLock (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .liveFrac(remSFrac_reg),
    .wholeRead(rdSWhole),
    .fracRead(rdSFrac),
    .shownFrac(shownSFrac)
  );

  tsr_frac_lock uUnsignedLock (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .liveFrac(remUFrac_reg),
    .wholeRead(rdUWhole),
    .fracRead(rdUFrac),
    .shownFrac(shownUFrac)
  );

  // ****************************************************************
  // Alarm comparators.
  // ****************************************************************
  tsr_hyst_alarm uOvertemp (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .update(convDone),
    .localTemp(localWhole),
    .remoteTemp(remoteUnsignedWhole),
    .remoteFault(diodeFault),
    .localLimit(localLimit_reg),
    .remoteLimit(remoteOt_reg),
    .hysteresis(hyst_reg),
    .localMask(genCfg_reg[TSR_GC_LOCAL_OT_MASK]),
    .remoteMask(genCfg_reg[TSR_GC_REMOTE_OT_MASK]),
    .faultMask(diodeCfg_reg[TSR_DC_FAULT_MASK_OT]),
    .alarm(otAlarm)
  );

  tsr_hyst_alarm uCritical (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .update(convDone),
    .localTemp(localWhole),
    .remoteTemp(remoteUnsignedWhole),
    .remoteFault(diodeFault),
    .localLimit(localLimit_reg),
    .remoteLimit(remoteCrit_reg),
    .hysteresis(hyst_reg),
    .localMask(genCfg_reg[TSR_GC_LOCAL_CRIT_MASK]),
    .remoteMask(genCfg_reg[TSR_GC_REMOTE_CRIT_MASK]),
    .faultMask(diodeCfg_reg[TSR_DC_FAULT_MASK_CRIT]),
    .alarm(critAlarm)
  );

  // ****************************************************************
  // Read path.
  // ****************************************************************
  // Read mux; unmapped and write-only pointers return zero.
  always_comb
  begin
    rdData_next = TSR_ZERO_BYTE;
    case (pointer_bits_reg)
      TSR_PTR_LOCAL_WHOLE: rdData_next = localWhole_reg;
      TSR_PTR_LOCAL_FRAC: rdData_next = localFrac_reg;
      TSR_PTR_REMOTE_S_WHOLE: rdData_next = remSWhole_reg;
      TSR_PTR_REMOTE_S_FRAC: rdData_next = shownSFrac;
      TSR_PTR_REMOTE_U_WHOLE: rdData_next = remUWhole_reg;
      TSR_PTR_REMOTE_U_FRAC: rdData_next = shownUFrac;
      TSR_PTR_GEN_CFG_A, TSR_PTR_GEN_CFG_B:
        rdData_next = genCfg_reg;
      TSR_PTR_CONV_INT_A, TSR_PTR_CONV_INT_B:
        rdData_next = convInt_reg;
      TSR_PTR_REMOTE_OT_A, TSR_PTR_REMOTE_OT_B:
        rdData_next = remoteOt_reg;
      TSR_PTR_REMOTE_CRIT: rdData_next = remoteCrit_reg;
      TSR_PTR_LOCAL_LIMIT: rdData_next = localLimit_reg;
      TSR_PTR_HYSTERESIS: rdData_next = hyst_reg;
      TSR_PTR_OFFSET_HIGH: rdData_next = offHigh_reg;
      TSR_PTR_OFFSET_LOW: rdData_next = offLow_reg;
      TSR_PTR_DIODE_CFG: rdData_next = diodeCfg_reg;
      TSR_PTR_STATUS_FIRST:
      begin
        rdData_next[TSR_S1_BUSY] = convBusy;
        rdData_next[TSR_S1_REMOTE_OT] = statRemOt_reg;
        rdData_next[TSR_S1_FAULT] = statFault_reg;
        rdData_next[TSR_S1_REMOTE_CRIT] = statRemCrit_reg;
        rdData_next[TSR_S1_LOCAL] = statLocal_reg;
      end
      TSR_PTR_STATUS_SECOND:
      begin
        rdData_next[TSR_S2_NOT_READY] = convNotReady;
        rdData_next[TSR_S2_DIODE_DETECT] = diodeDetected;
      end
      TSR_PTR_MAKER: rdData_next = MAKER_CODE;
      TSR_PTR_REVISION: rdData_next = REVISION_CODE;
      default: rdData_next = TSR_ZERO_BYTE;
    endcase
  end

  // Read data is captured on the read strobe and held until the next.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdData <= TSR_ZERO_BYTE;
    else if (clkEn && rdStrobe)
      rdData <= rdData_next;
  end

  // ****************************************************************
  // Outputs to the engine and pins.
  // ****************************************************************
  // Copies of control fields and alarms, registered for clean pins.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      standbyMode <= 1'b0;
      convInterval <= TSR_RST_CONV_INT[1:0];
      filterSelect <= TSR_RST_DIODE_CFG[TSR_DC_FILTER_HI:TSR_DC_FILTER_LO];
      diodeModel <= TSR_RST_DIODE_CFG[TSR_DC_DIODE_MODEL];
      offsetHigh <= TSR_RST_OFFSET;
      offsetLow <= TSR_RST_OFFSET;
      overtemp_alarm_output_n <= 1'b1;
      critAlarm_n <= 1'b1;
      alarm_or_address_pin_is_alarm <= TSR_RST_DIODE_CFG[TSR_DC_PIN_IS_ALARM];
    end
    else if (clkEn)
    begin
      standbyMode <= genCfg_reg[TSR_GC_STANDBY];
      convInterval <= convInt_reg[1:0];
      filterSelect <= diodeCfg_reg[TSR_DC_FILTER_HI:TSR_DC_FILTER_LO];
      diodeModel <= diodeCfg_reg[TSR_DC_DIODE_MODEL];
      offsetHigh <= offHigh_reg;
      offsetLow <= offLow_reg;
      overtemp_alarm_output_n <= !(otAlarm &&
        diodeCfg_reg[TSR_DC_PIN_IS_ALARM]);
      critAlarm_n <= !critAlarm;
      alarm_or_address_pin_is_alarm <= diodeCfg_reg[TSR_DC_PIN_IS_ALARM];
    end
  end
endmodule
`default_nettype wire

/* tsr_engine_model.sv */
// Conversion engine stand-in that answers one-shot starts.
`default_nettype none
module tsr_engine_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Start request and result handshake.
  input wire logic oneShotStart,
  output logic convBusy,
  output logic convDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt;
  // Busy for three cycles after a start, done on the last one.
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      cnt <= 2'h0;
    else if (oneShotStart)
      cnt <= 2'h3;
    else if (cnt != 2'h0)
      cnt <= cnt - 2'h1;
  // Handshake levels decoded from the count.
  assign convBusy = (cnt != 2'h0);
  assign convDone = (cnt == 2'h1);
endmodule
`default_nettype wire

/* tsr_register_bank_monitor.sv */
// Port checker for the temperature sensor register bank.
`default_nettype none
module tsr_checker (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Watched ports.
  input wire logic wrValid,
  input wire logic rdStrobe,
  input wire logic [7:0] rdData,
  input wire logic convDone,
  input wire logic convBusy,
  input wire logic standbyMode,
  input wire logic [1:0] convInterval,
  input wire logic oneShotStart,
  input wire logic [1:0] filterSelect,
  input wire logic overtemp_alarm_output_n,
  input wire logic critAlarm_n,
  input wire logic alarm_or_address_pin_is_alarm
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  rd_hold_a: assert property (!$past(rdStrobe) |-> $stable(rdData))
    else $error("read data moved without a read");
  shot_pulse_a: assert property (oneShotStart |=> !oneShotStart)
    else $error("start pulse too long");
  shot_cause_a: assert property ($rose(oneShotStart) |->
    $past(wrValid) && !$past(convBusy)) else $error("start without write");
  busy_block_a: assert property (convBusy |=> !oneShotStart)
    else $error("start while busy");
  reset_vals_a: assert property ($rose(reset_n) |->
    convInterval == 2'h2 && filterSelect == 2'h3 && !standbyMode)
    else $error("bad control values after reset");
  pin_sel_a: assert property (!overtemp_alarm_output_n |->
    alarm_or_address_pin_is_alarm) else $error("alarm on address pin");
  crit_src_a: assert property ($changed(critAlarm_n) |->
    $past(convDone, 2)) else $error("alarm moved without conversion");
  stby_src_a: assert property ($changed(standbyMode) |->
    $past(wrValid, 2)) else $error("standby moved without write");
endmodule
bind tsr_register_bank tsr_checker u_chk (.*);
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the temperature sensor register bank.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, reset_n = 1'b0, otN, critN;
  logic cmdValid = 1'b0, wrValid = 1'b0, rdStrobe = 1'b0;
  logic convDone, convBusy, oneShotStart;
  logic [7:0] cmdByte = 8'h00, wrData = 8'h00, rdData;
  logic [7:0] localWhole = 8'h19, localFrac = 8'hFF;
  logic [7:0] remoteSignedWhole = 8'hF6, remoteSignedFrac = 8'hFF;
  logic [7:0] remoteUnsignedWhole = 8'h10, remoteUnsignedFrac = 8'hFF;
  int n_mismatch = 0, compares = 0;
  // Bank under test and the engine stand-in.
  tsr_register_bank u_dut (.ref_clk, .reset_n, .clkEn(1'b1), .cmdValid,
    .cmdByte, .wrValid, .wrData, .rdStrobe, .rdData, .convDone, .convBusy,
    .convNotReady(1'b1), .diodeDetected(1'b1), .diodeFault(1'b0),
    .localWhole, .localFrac, .remoteSignedWhole, .remoteSignedFrac,
    .remoteUnsignedWhole, .remoteUnsignedFrac, .standbyMode(),
    .convInterval(), .oneShotStart, .filterSelect(), .diodeModel(),
    .offsetHigh(), .offsetLow(), .overtemp_alarm_output_n(otN),
    .critAlarm_n(critN), .alarm_or_address_pin_is_alarm());
  tsr_engine_model u_eng (.ref_clk, .reset_n, .oneShotStart, .convBusy,
    .convDone);
  // Free-running 125 MHz clock.
  initial forever #4 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [7:0] e, g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Pointer cycle, then one write or read cycle, driven at falling edges.
  task automatic acc(input logic [7:0] p, input logic [7:0] d, input bit w);
    @(negedge ref_clk);
    cmdValid = 1'b1;
    cmdByte = p;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    wrValid = w;
    rdStrobe = !w;
    wrData = d;
    @(negedge ref_clk);
    wrValid = 1'b0;
    rdStrobe = 1'b0;
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    acc(p, 8'h00, 1'b0);
    chk($sformatf("register %h", p), e, rdData);
  endtask
  // One-shot start, a second start while busy, then wait for the engine.
  task automatic conv;
    acc(8'h0F, 8'hA5, 1'b1);
    acc(8'h0F, 8'hA5, 1'b1);
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic test_reset;
    logic [7:0] p[14] = '{8'h03, 8'h04, 8'h07, 8'h0D, 8'h11, 8'h12, 8'h19,
      8'h20, 8'h21, 8'hBF, 8'hFE, 8'hFF, 8'h0F, 8'h33};
    logic [7:0] v[14] = '{8'h00, 8'h02, 8'h55, 8'h55, 8'h00, 8'h00, 8'h6E,
      8'h55, 8'h0A, 8'h1F, 8'h5A, 8'h3C, 8'h00, 8'h81};
    @(negedge ref_clk);
    rdStrobe = 1'b1;
    @(negedge ref_clk);
    rdStrobe = 1'b0;
    chk("read without pointer", 8'h00, rdData);
    foreach (p[i])
      rd(p[i], v[i]);
    $display("reset values done");
  endtask
  task automatic test_write;
    logic [7:0] w[10] = '{8'h09, 8'h0A, 8'h20, 8'h12, 8'hBF, 8'h21, 8'h19,
      8'h11, 8'h00, 8'hFE};
    logic [7:0] d[10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF0,
      8'h80, 8'hAA, 8'h00};
    logic [7:0] r[10] = '{8'h03, 8'h04, 8'h20, 8'h12, 8'hBF, 8'h21, 8'h19,
      8'h11, 8'h00, 8'hFE};
    logic [7:0] v[10] = '{8'h5E, 8'h03, 8'h7F, 8'hE0, 8'h7F, 8'h1F, 8'hF0,
      8'h80, 8'h00, 8'h5A};
    foreach (w[i])
    begin
      acc(w[i], d[i], 1'b1);
      rd(r[i], v[i]);
    end
    $display("write readback done");
  endtask
  task automatic test_convert;
    conv();
    rd(8'h00, 8'h19);
    rd(8'h30, 8'hE0);
    rd(8'h01, 8'hF6);
    rd(8'h31, 8'h10);
    remoteSignedFrac = 8'h00;
    conv();
    rd(8'h10, 8'hF8);
    rd(8'h10, 8'h00);
    acc(8'hBF, 8'h79, 1'b1);
    remoteSignedFrac = 8'hFF;
    conv();
    rd(8'h10, 8'hE0);
    rd(8'h32, 8'hF8);
    $display("conversion and lock done");
  endtask
  task automatic test_alarm;
    acc(8'h03, 8'h40, 1'b1);
    remoteUnsignedWhole = 8'hF8;
    conv();
    chk("alarm pins", 8'h00, {6'h00, otN, critN});
    rd(8'h02, 8'h12);
    remoteUnsignedWhole = 8'hE0;
    conv();
    chk("alarm pins", 8'h00, {6'h00, otN, critN});
    remoteUnsignedWhole = 8'h30;
    conv();
    chk("alarm pins", 8'h03, {6'h00, otN, critN});
    $display("alarm hysteresis done");
  endtask
  task automatic summarize;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence: reset for six cycles, then each test in turn.
  initial
  begin
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    test_reset();
    test_write();
    test_convert();
    test_alarm();
    summarize();
  end
  // Watchdog that cuts a hang short.
  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
